//--- apb_cfg_source.sv
// apb configuration source model that programs the hub register slice
module apb_cfg_source (
    input wire logic sys_clk, // clock
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [11:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    output logic [3:0] pstrb, // strobes
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {psel, penable, pwrite, pstrb} <= 7'h0;
        paddr <= 12'h0;
        pwdata <= 32'h0;
    end
    // one transfer; the caller keeps budgets and lengths legal unless testing flags
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
            input logic [3:0] strb, output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        pstrb <= strb;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a stuck wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep showing the last value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule // apb_cfg_source

//--- hub_cfg_pkg.sv
// constants for the hub power and string configuration register slice
package hub_cfg_pkg;
    localparam int REG_COUNT = 7;
    localparam int ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SELF = 8'h0e;
    localparam logic [7:0] IDX_BUS = 8'h0f;
    localparam logic [7:0] IDX_DELAY = 8'h10;
    localparam logic [7:0] IDX_LANG_UP = 8'h11;
    localparam logic [7:0] IDX_LANG_LO = 8'h12;
    localparam logic [7:0] IDX_MAKER_LEN = 8'h13;
    localparam logic [7:0] IDX_PROD_LEN = 8'h14;
    localparam logic [7:0] IDX_LIMIT = 8'h3f;
    // storage slots, plus the limit slot that reads the flags
    localparam logic [2:0] SLOT_SELF = 3'h0;
    localparam logic [2:0] SLOT_BUS = 3'h1;
    localparam logic [2:0] SLOT_DELAY = 3'h2;
    localparam logic [2:0] SLOT_LANG_UP = 3'h3;
    localparam logic [2:0] SLOT_LANG_LO = 3'h4;
    localparam logic [2:0] SLOT_MAKER_LEN = 3'h5;
    localparam logic [2:0] SLOT_PROD_LEN = 3'h6;
    localparam logic [2:0] SLOT_LIMIT = 3'h7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // units and budgets
    localparam int CURRENT_UNIT_MA = 2;
    localparam int POWER_UNIT_MS = 2;
    localparam int SELF_BUDGET_MA = 100;
    localparam logic [7:0] SELF_LIMIT_COUNT = 8'(SELF_BUDGET_MA / CURRENT_UNIT_MA);
    localparam logic [7:0] NAME_LEN_MAX = 8'h1f;
    // limit register bit positions
    localparam int LIM_SELF_BIT = 0;
    localparam int LIM_MAKER_BIT = 1;
    localparam int LIM_PROD_BIT = 2;
    // string descriptor framing
    localparam logic [7:0] STR_DESC_TYPE = 8'h03;
    localparam logic [7:0] LANG_DESC_LEN = 8'h04;
    localparam logic [7:0] STR_DESC_HDR = 8'h02;
    localparam logic [1:0] DSEL_LEN = 2'h0;
    localparam logic [1:0] DSEL_TYPE = 2'h1;
    localparam logic [1:0] DSEL_LO = 2'h2;
    localparam logic [1:0] DSEL_UP = 2'h3;
endpackage

//--- hub_power_string_config_regs.sv
// register slice for hub current budgets, power-good delay, language id, string lengths
// What this block does
// - holds the self-powered controller current as an 8-bit count of 2 mA.
// - holds the bus-powered controller current as an 8-bit count of 2 mA.
// - the bus-powered current figure leaves out any attached compound peripheral.
// - stores the port power-on to power-good delay in 2 ms steps.
// - the upper language register gives the high byte of the 16-bit language id.
// - the lower language register gives the low byte of the 16-bit language id.
// - the maker name length register gives the length in characters; above 31 it only sets a limit flag.
// - the product name length register gives the length in characters; above 31 it only sets a limit flag.
// - each 16-bit string unit goes out low byte first, units in address order.
module hub_power_string_config_regs (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic rst, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    input wire logic selfPoweredPin, // board power mode pin
    input wire logic [1:0] descSel, // language descriptor byte select
    output logic selfPowered, // filtered power mode
    output logic [7:0] selfCurrent, // self-powered count
    output logic [7:0] busCurrent, // bus-powered count
    output logic [7:0] powerGoodDelay, // delay in 2 ms steps
    output logic [15:0] langId, // language id
    output logic [7:0] makerNameLen, // maker length
    output logic [7:0] productNameLen, // product length
    output logic [7:0] makerDescLen, // maker descriptor length
    output logic [7:0] productDescLen, // product descriptor length
    output logic [8:0] hubContrCurrentMa, // controller current in mA
    output logic [7:0] descByte, // language descriptor byte
    output logic [2:0] limitFlags // budgets exceeded
);

    typedef struct packed {
        logic [hub_cfg_pkg::REG_COUNT-1:0][7:0] cfg;
        logic [2:0] syncPipe;
        logic selfPowered;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] selfCurrent;
        logic [7:0] busCurrent;
        logic [7:0] powerGoodDelay;
        logic [15:0] langId;
        logic [7:0] makerNameLen;
        logic [7:0] productNameLen;
        logic [7:0] makerDescLen;
        logic [7:0] productDescLen;
        logic [8:0] hubContrCurrentMa;
        logic [7:0] descByte;
        logic [2:0] limitFlags;
    } state_type;

    state_type st;
    state_type next_st;

    // address decode: {hit, slot}; unaligned or out-of-range misses
    function automatic logic [3:0] decodeAddr(input logic [11:0] a);
        logic [3:0] r;
        r = 4'h0;
        if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
            case (a[9:2])
                hub_cfg_pkg::IDX_SELF: r = {1'b1, hub_cfg_pkg::SLOT_SELF};
                hub_cfg_pkg::IDX_BUS: r = {1'b1, hub_cfg_pkg::SLOT_BUS};
                hub_cfg_pkg::IDX_DELAY: r = {1'b1, hub_cfg_pkg::SLOT_DELAY};
                hub_cfg_pkg::IDX_LANG_UP: r = {1'b1, hub_cfg_pkg::SLOT_LANG_UP};
                hub_cfg_pkg::IDX_LANG_LO: r = {1'b1, hub_cfg_pkg::SLOT_LANG_LO};
                hub_cfg_pkg::IDX_MAKER_LEN: r = {1'b1, hub_cfg_pkg::SLOT_MAKER_LEN};
                hub_cfg_pkg::IDX_PROD_LEN: r = {1'b1, hub_cfg_pkg::SLOT_PROD_LEN};
                hub_cfg_pkg::IDX_LIMIT: r = {1'b1, hub_cfg_pkg::SLOT_LIMIT};
                default: r = 4'h0;
            endcase
        end
        return r;
    endfunction

    // string descriptor length: two header bytes plus two per character
    function automatic logic [7:0] descLen(input logic [7:0] chars);
        return {chars[6:0], 1'b0} + hub_cfg_pkg::STR_DESC_HDR;
    endfunction

    logic [3:0] dec;
    logic [2:0] slot;
    logic accessFirst;
    logic accessDone;
    logic [7:0] powerSel;

    assign dec = decodeAddr(paddr);
    assign slot = dec[2:0];
    // one wait state: ready rises in the second access cycle
    assign accessFirst = psel && penable && !st.pready;
    assign accessDone = psel && penable && st.pready;

    always_comb begin
        next_st = st;
        powerSel = 8'h00;
        // power mode pin: three flops, taken once second and third agree
        next_st.syncPipe = {st.syncPipe[1:0], selfPoweredPin};
        if (st.syncPipe[1] == st.syncPipe[2]) begin
            next_st.selfPowered = st.syncPipe[2];
        end
        next_st.pready = accessFirst;
        next_st.pslverr = accessFirst && !dec[3];
        // read data is captured one cycle ahead, held until completion
        if (accessFirst) begin
            next_st.prdata = 32'h0000_0000;
            if (dec[3] && slot == hub_cfg_pkg::SLOT_LIMIT) begin
                next_st.prdata[2:0] = st.limitFlags;
            end else if (dec[3]) begin
                next_st.prdata[7:0] = st.cfg[slot];
            end
        end
        // write lands only at the completing edge; limit register is read only
        if (accessDone && pwrite && dec[3] && pstrb[0]
            && slot != hub_cfg_pkg::SLOT_LIMIT) begin
            next_st.cfg[slot] = pwdata[7:0];
        end
        // outputs follow the new settings at the same edge
        next_st.selfCurrent = next_st.cfg[hub_cfg_pkg::SLOT_SELF];
        next_st.busCurrent = next_st.cfg[hub_cfg_pkg::SLOT_BUS];
        next_st.powerGoodDelay = next_st.cfg[hub_cfg_pkg::SLOT_DELAY];
        next_st.langId = {next_st.cfg[hub_cfg_pkg::SLOT_LANG_UP],
            next_st.cfg[hub_cfg_pkg::SLOT_LANG_LO]};
        next_st.makerNameLen = next_st.cfg[hub_cfg_pkg::SLOT_MAKER_LEN];
        next_st.productNameLen = next_st.cfg[hub_cfg_pkg::SLOT_PROD_LEN];
        next_st.makerDescLen = descLen(next_st.makerNameLen);
        next_st.productDescLen = descLen(next_st.productNameLen);
        // bus figure carries no compound peripheral share, so no adjustment
        powerSel = next_st.selfPowered ? next_st.selfCurrent : next_st.busCurrent;
        next_st.hubContrCurrentMa = {powerSel, 1'b0};
        // flags only report; software stays in charge of the limits
        next_st.limitFlags[hub_cfg_pkg::LIM_SELF_BIT] =
            next_st.selfCurrent > hub_cfg_pkg::SELF_LIMIT_COUNT;
        next_st.limitFlags[hub_cfg_pkg::LIM_MAKER_BIT] =
            next_st.makerNameLen > hub_cfg_pkg::NAME_LEN_MAX;
        next_st.limitFlags[hub_cfg_pkg::LIM_PROD_BIT] =
            next_st.productNameLen > hub_cfg_pkg::NAME_LEN_MAX;
        // language descriptor: length, type, then id low byte first
        case (descSel)
            hub_cfg_pkg::DSEL_LEN: next_st.descByte = hub_cfg_pkg::LANG_DESC_LEN;
            hub_cfg_pkg::DSEL_TYPE: next_st.descByte = hub_cfg_pkg::STR_DESC_TYPE;
            hub_cfg_pkg::DSEL_LO: next_st.descByte = next_st.langId[7:0];
            hub_cfg_pkg::DSEL_UP: next_st.descByte = next_st.langId[15:8];
            default: next_st.descByte = 8'h00;
        endcase
    end

    // state register; reset loads constants only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from the state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign selfPowered = st.selfPowered;
    assign selfCurrent = st.selfCurrent;
    assign busCurrent = st.busCurrent;
    assign powerGoodDelay = st.powerGoodDelay;
    assign langId = st.langId;
    assign makerNameLen = st.makerNameLen;
    assign productNameLen = st.productNameLen;
    assign makerDescLen = st.makerDescLen;
    assign productDescLen = st.productDescLen;
    assign hubContrCurrentMa = st.hubContrCurrentMa;
    assign descByte = st.descByte;
    assign limitFlags = st.limitFlags;

    // checks on the behaviour above
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // completing write to a given index
    sequence wrDone(logic [7:0] idx);
        psel && penable && pready && pwrite && pstrb[0] && paddr == {2'h0, idx, 2'h0};
    endsequence

    sequence firstAccess;
        psel && penable && !pready;
    endsequence

    // first access cycle of a read at a given index
    sequence rdFirst(logic [7:0] idx);
        psel && penable && !pready && !pwrite && paddr == {2'h0, idx, 2'h0};
    endsequence

    // pin moved, then held through the filter span
    sequence pinSettled;
        $changed(selfPoweredPin) ##1 $stable(selfPoweredPin) [*3];
    endsequence

    // read data shows the setting that stood at the capture edge
    property readBack(logic [7:0] idx, logic [7:0] val);
        rdFirst(idx) |=> pready && prdata == {24'h0, $past(val)};
    endproperty

    AST_READY_ONE_WAIT: assert property (firstAccess |=> pready ##1 !pready)
        else $error("ready not a single cycle after one wait");

    AST_SELF_WRITE: assert property (
        wrDone(hub_cfg_pkg::IDX_SELF) |=> selfCurrent == $past(pwdata[7:0]))
        else $error("self current not stored");

    AST_BUS_WRITE: assert property (
        wrDone(hub_cfg_pkg::IDX_BUS) |=> busCurrent == $past(pwdata[7:0]))
        else $error("bus current not stored");

    AST_BUS_MA: assert property (
        !selfPowered && $stable(selfPowered) |-> hubContrCurrentMa == {busCurrent, 1'b0})
        else $error("bus figure altered");

    AST_DELAY_WRITE: assert property (
        wrDone(hub_cfg_pkg::IDX_DELAY) |=> powerGoodDelay == $past(pwdata[7:0]))
        else $error("power good delay not stored");

    AST_LANG_UPPER: assert property (
        wrDone(hub_cfg_pkg::IDX_LANG_UP) |=> langId[15:8] == $past(pwdata[7:0])
            && $stable(langId[7:0]))
        else $error("language high byte wrong");

    AST_LANG_LOWER: assert property (
        wrDone(hub_cfg_pkg::IDX_LANG_LO) |=> langId[7:0] == $past(pwdata[7:0])
            && $stable(langId[15:8]))
        else $error("language low byte wrong");

    AST_MAKER_LEN: assert property (
        wrDone(hub_cfg_pkg::IDX_MAKER_LEN) |=> makerNameLen == $past(pwdata[7:0])
            && limitFlags[1] == (makerNameLen > 8'h1f))
        else $error("maker length or flag wrong");

    AST_PROD_LEN: assert property (
        wrDone(hub_cfg_pkg::IDX_PROD_LEN) |=> productNameLen == $past(pwdata[7:0])
            && limitFlags[2] == (productNameLen > 8'h1f))
        else $error("product length or flag wrong");

    AST_LOW_FIRST: assert property (
        descSel == 2'h2 && !(psel && penable && pready && pwrite)
            |=> descByte == $past(langId[7:0]))
        else $error("language low byte not at lower position");

    AST_DESC_LEN: assert property (
        wrDone(hub_cfg_pkg::IDX_MAKER_LEN) ##1 1'b1 |->
            makerDescLen == 8'({makerNameLen[6:0], 1'b0} + 8'h02))
        else $error("maker descriptor length wrong");

    AST_PROD_DESC_LEN: assert property (
        wrDone(hub_cfg_pkg::IDX_PROD_LEN) ##1 1'b1 |->
            productDescLen == 8'(2 * productNameLen + 2))
        else $error("product descriptor length wrong");

    // the high byte follows the low one in the language descriptor
    AST_HIGH_SECOND: assert property (
        descSel == 2'h3 && !(psel && penable && pready && pwrite)
            |=> descByte == $past(langId[15:8]))
        else $error("language high byte not at upper position");

    AST_DESC_HEAD: assert property (descSel == 2'h0 |=> descByte == 8'h04)
        else $error("language descriptor length byte wrong");

    AST_DESC_TYPE: assert property (descSel == 2'h1 |=> descByte == 8'h03)
        else $error("language descriptor type byte wrong");

    // readback of every setting over the bus
    AST_READ_SELF: assert property (
        readBack(hub_cfg_pkg::IDX_SELF, selfCurrent))
        else $error("self current reads back wrong");

    AST_READ_BUS: assert property (
        readBack(hub_cfg_pkg::IDX_BUS, busCurrent))
        else $error("bus current reads back wrong");

    AST_READ_DELAY: assert property (
        readBack(hub_cfg_pkg::IDX_DELAY, powerGoodDelay))
        else $error("power good delay reads back wrong");

    AST_READ_LANG_UP: assert property (
        readBack(hub_cfg_pkg::IDX_LANG_UP, langId[15:8]))
        else $error("language high byte reads back wrong");

    AST_READ_LANG_LO: assert property (
        readBack(hub_cfg_pkg::IDX_LANG_LO, langId[7:0]))
        else $error("language low byte reads back wrong");

    AST_READ_MAKER: assert property (
        readBack(hub_cfg_pkg::IDX_MAKER_LEN, makerNameLen))
        else $error("maker length reads back wrong");

    AST_READ_PROD: assert property (
        readBack(hub_cfg_pkg::IDX_PROD_LEN, productNameLen))
        else $error("product length reads back wrong");

    AST_READ_LIMIT: assert property (
        rdFirst(hub_cfg_pkg::IDX_LIMIT) |=> prdata == {29'h0, $past(limitFlags)})
        else $error("limit flags read back wrong");

    // flags only report, so the self budget flag tracks the value itself
    AST_SELF_FLAG: assert property (limitFlags[0] == (selfCurrent > 8'h32))
        else $error("self budget flag wrong");

    AST_SELF_MA: assert property (
        selfPowered |-> hubContrCurrentMa == {selfCurrent, 1'b0})
        else $error("self figure altered");

    // refused writes: masked low strobe or unmapped address keep every setting
    AST_STRB_MASKED: assert property (
        psel && penable && pready && pwrite && !pstrb[0] |=> $stable(selfCurrent)
            && $stable(busCurrent) && $stable(powerGoodDelay) && $stable(langId)
            && $stable(makerNameLen) && $stable(productNameLen))
        else $error("masked write changed a setting");

    AST_UNMAPPED_KEEP: assert property (
        pready && pslverr && pwrite |=> $stable(selfCurrent)
            && $stable(busCurrent) && $stable(powerGoodDelay) && $stable(langId)
            && $stable(makerNameLen) && $stable(productNameLen))
        else $error("unmapped write changed a setting");

    // error answers carry no data and come only with ready
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer malformed");

    // a pin level held through the filter reaches the output one edge later
    AST_SYNC_SETTLE: assert property (pinSettled |=> selfPowered == $past(selfPoweredPin))
        else $error("power mode pin not taken after filtering");

    // every setting leaves reset at zero; reset itself is the trigger here
    AST_RESET_ZERO: assert property (disable iff (1'b0) $fell(rst) |->
        selfCurrent == 8'h00 && busCurrent == 8'h00 && powerGoodDelay == 8'h00
            && langId == 16'h0000 && makerNameLen == 8'h00 && productNameLen == 8'h00
            && !pready && !pslverr && prdata == 32'h0000_0000)
        else $error("settings not cleared by reset");

endmodule // hub_power_string_config_regs

//--- test_hub_power_string_config_regs.sv
// self-checking bench for the hub power and string register slice
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
module test_hub_power_string_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic selfPoweredPin = 1'b0;
    logic [1:0] descSel = 2'h0;
    logic psel, penable, pwrite, pready, pslverr, err, selfPowered;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] selfCurrent, busCurrent, powerGoodDelay, makerNameLen, productNameLen;
    logic [7:0] makerDescLen, productDescLen, descByte;
    logic [15:0] langId;
    logic [8:0] hubContrCurrentMa;
    logic [2:0] limitFlags;
    int failures = 0;
    int checks_done = 0;
    always #2.5 sys_clk = ~sys_clk;
    apb_cfg_source src (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    hub_power_string_config_regs dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .selfPoweredPin(selfPoweredPin),
        .descSel(descSel), .selfPowered(selfPowered), .selfCurrent(selfCurrent),
        .busCurrent(busCurrent), .powerGoodDelay(powerGoodDelay), .langId(langId),
        .makerNameLen(makerNameLen), .productNameLen(productNameLen),
        .makerDescLen(makerDescLen), .productDescLen(productDescLen),
        .hubContrCurrentMa(hubContrCurrentMa), .descByte(descByte), .limitFlags(limitFlags));
    // one bus cycle, then let the updates land
    task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
            input logic [3:0] strb);
        src.xfer(wr, idx, wd, strb, rd, err);
        @(posedge sys_clk);
        #1;
    endtask
    // each of the seven settings registers, 0x0e to 0x14, reads zero after reset
    task automatic t_reset();
        for (int i = 14; i <= 20; i++) begin
            acc(1'b0, 8'(i), 8'h00, 4'hf);
            `CHK({err, rd}, 33'h0)
        end
        `CHK({langId, selfCurrent, limitFlags}, 27'h0)
        $display("test reset done");
    endtask
    // write each of the seven settings registers, read back, watch the reported values
    task automatic t_rw();
        logic [7:0] v[7] = '{8'h32, 8'hfa, 8'h64, 8'h04, 8'h09, 8'h1f, 8'h05};
        logic [7:0] d[4] = '{8'h04, 8'h03, 8'h09, 8'h04};
        for (int i = 0; i < 7; i++) acc(1'b1, 8'(14 + i), v[i], 4'hf);
        for (int i = 0; i < 7; i++) begin
            acc(1'b0, 8'(14 + i), 8'h00, 4'hf);
            `CHK(rd, {24'h0, v[i]})
        end
        `CHK(selfCurrent, 8'h32)
        `CHK(busCurrent, 8'hfa)
        `CHK(powerGoodDelay, 8'h64)
        `CHK(langId, 16'h0409)
        `CHK({makerNameLen, productNameLen}, 16'h1f05)
        `CHK({makerDescLen, productDescLen}, 16'h400c)
        `CHK(limitFlags, 3'h0)
        `CHK(hubContrCurrentMa, 9'h1f4)
        @(posedge sys_clk) selfPoweredPin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(hubContrCurrentMa, 9'h064)
        `CHK(selfPowered, 1'b1)
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) descSel <= 2'(i);
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK(descByte, d[i])
        end
        $display("test readwrite done");
    endtask
    // values past the budgets are flagged, not clipped
    task automatic t_limits();
        acc(1'b1, 8'h0e, 8'h33, 4'hf);
        acc(1'b1, 8'h13, 8'h20, 4'hf);
        acc(1'b1, 8'h14, 8'h20, 4'hf);
        acc(1'b1, 8'h3f, 8'h00, 4'hf);
        acc(1'b0, 8'h3f, 8'h00, 4'hf);
        `CHK({err, rd}, 33'h7)
        `CHK(limitFlags, 3'h7)
        `CHK(makerDescLen, 8'h42)
        `CHK(hubContrCurrentMa, 9'h066)
        $display("test limits done");
    endtask
    // unmapped address and masked strobe leave storage alone
    task automatic t_refuse();
        acc(1'b1, 8'h20, 8'haa, 4'hf);
        `CHK(err, 1'b1)
        acc(1'b0, 8'h20, 8'h00, 4'hf);
        `CHK({err, rd}, 33'h100000000)
        acc(1'b1, 8'h10, 8'h01, 4'he);
        acc(1'b0, 8'h10, 8'h00, 4'hf);
        `CHK(rd, 32'h64)
        $display("test refuse done");
    endtask
    // reset in mid-run clears every setting again
    task automatic t_rerun();
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK({selfCurrent, busCurrent, powerGoodDelay, langId}, 40'h0)
        `CHK({makerNameLen, productNameLen, limitFlags}, 19'h0)
        acc(1'b0, 8'h0e, 8'h00, 4'hf);
        `CHK({err, rd}, 33'h0)
        $display("test rerun done");
    endtask
    // verdict and end of run
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_rw();
        t_limits();
        t_refuse();
        t_rerun();
        results();
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #50000;
        failures++;
        results();
    end
endmodule // test_hub_power_string_config_regs
